// File: include/pwio_cfg.svh
/*
 * constants of the echo supervision and i/o setup block: timing, mode word bits, direction codes.
 * assumes a 50 MHz clock and that the protocol stack delivers decoded frame events.
 */
// How it works
// - dhcp enabled: wait about 40 s, then use static settings while still asking
// - with dhcp enabled, any dhcp answer is adopted at once and the interface is reconfigured
// - untagged and tagged frames accepted, in vlan mode a tagged frame's vlan id must match the setting
// - mac protection: source must match one of two macs, all zero disables
// - network filter limits only snmp and web; arp, icmp, dhcp always pass
// - mac check and network check both apply; a matching mac does not bypass the network check
// - incoming and outgoing supervision have own timers, one shared minute timeout
// - timer expiry gives a restart pulse and, with the clear option, resets the i/o ports
// - incoming mode expects an echo request each timeout window
// - outgoing mode pings the remote several times a minute, needs a reply
// - restart pulse width is 0 to 32767 times 250 ms
// - restart can mirror onto relay pins, be forced, and be enabled or stopped
// - clear option drives every output of both ports low on a timer restart; mirrored relay pins stay high until the restart ends
// - ping indicator toggles once per echo request to own address
// - second indicator shows power, ping in, ping out, both, or dhcp valid
// - each pin has own direction; code 1 is output, 2 is input
// - input pins get a 50 kohm pull, output pins none
// - per pin pull select: 1 pull down, 0 pull up
// - mode bit 3 disables all input pulls at once
// - outputs start at zero; retain option saves changes and restores at boot
// - adc filter smooths readings unless the mode bit disables it
`ifndef PWIO_CFG_SVH
`define PWIO_CFG_SVH
`define PWIO_CLK_HZ 50000000
`define PWIO_DHCP_WAIT_S 40
`define PWIO_DHCP_WAIT_CYC (`PWIO_DHCP_WAIT_S * `PWIO_CLK_HZ)
`define PWIO_TICK_MS 250
`define PWIO_TICK_CYC (`PWIO_TICK_MS * (`PWIO_CLK_HZ / 1000))
`define PWIO_TICKS_PER_MIN 240
`define PWIO_PING_EVERY_TICKS 40
`define PWIO_BIT_VLAN 0
`define PWIO_BIT_SNMP 1
`define PWIO_BIT_RESTART_EN 2
`define PWIO_BIT_NO_PULL 3
`define PWIO_BIT_NO_FILTER 4
`define PWIO_BIT_DHCP 0
`define PWIO_BIT_IN_MON 1
`define PWIO_BIT_OUT_MON 2
`define PWIO_BIT_CLR_IO 3
`define PWIO_BIT_PING_LED 4
`define PWIO_BIT_RETAIN 5
`define PWIO_DIR_OUT 2'h1
`define PWIO_DIR_IN 2'h2
`define PWIO_FILT_SHIFT 3
`endif

// File: include/pwio_pkg.sv
/*
 * types of the echo supervision and i/o setup block.
 * assumes nothing beyond the cfg header.
 */
package pwio_pkg;
    typedef enum logic [2:0] {
        PWIO_LED_POWER, PWIO_LED_PING_IN, PWIO_LED_PING_OUT, PWIO_LED_PING_BOTH, PWIO_LED_DHCP
    } pwio_led_t;
    typedef enum {PWIO_NET_WAIT, PWIO_NET_STATIC, PWIO_NET_DHCP} pwio_net_t;
endpackage : pwio_pkg

// File: rtl/pwio_adc_filt.sv
/*
 * per channel adc smoothing with a small value memory, read data registered.
 * assumes one sample strobe carries channel index and raw value.
 */
`timescale 1ns/10ps
`include "pwio_cfg.svh"
module pwio_adc_filt #(
    parameter int CH = 8,
    parameter int W = 10
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_filter_on,
    input wire logic i_valid,
    input wire logic [$clog2(CH)-1:0] i_chan,
    input wire logic [W-1:0] i_raw,
    output logic o_valid,
    output logic [$clog2(CH)-1:0] o_chan,
    output logic [W-1:0] o_value
);
    logic [W+`PWIO_FILT_SHIFT-1:0] acc [CH];
    wire [W+`PWIO_FILT_SHIFT-1:0] old_acc = acc[i_chan];
    wire [W+`PWIO_FILT_SHIFT-1:0] next_acc = old_acc - (old_acc >> `PWIO_FILT_SHIFT)
        + {{`PWIO_FILT_SHIFT{1'b0}}, i_raw};
    wire [W+`PWIO_FILT_SHIFT-1:0] raw_acc = {i_raw, {`PWIO_FILT_SHIFT{1'b0}}};
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            for (int k = 0; k < CH; k++) begin
                acc[k] <= '0;
            end
        end else if (i_valid) begin
            acc[i_chan] <= i_filter_on ? next_acc : raw_acc;
        end
    end
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_valid <= 1'b0;
            o_chan <= '0;
            o_value <= '0;
        end else begin
            o_valid <= i_valid;
            o_chan <= i_chan;
            o_value <= i_filter_on ? next_acc[W+`PWIO_FILT_SHIFT-1:`PWIO_FILT_SHIFT] : i_raw;
        end
    end
endmodule : pwio_adc_filt

// File: rtl/pwio_top.sv
/*
 * echo supervision, restart pulse, access filter, network settings and i/o setup.
 * assumes frame events come decoded from a protocol stack as one-cycle strobes.
 */
`timescale 1ns/10ps
`include "pwio_cfg.svh"
module pwio_top #(
    parameter int N = 8,
    parameter int unsigned DHCP_WAIT_CYC = `PWIO_DHCP_WAIT_CYC,
    parameter int unsigned TICK_CYC = `PWIO_TICK_CYC
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [7:0] i_main_mode_word,
    input wire logic [7:0] i_extended_mode_word,
    input wire logic [31:0] i_device_ip_setting,
    input wire logic [31:0] i_subnet_mask_setting,
    input wire logic [31:0] i_gateway_setting,
    input wire logic [11:0] i_vlan_id_setting,
    input wire logic [47:0] i_allowed_mac_one,
    input wire logic [47:0] i_allowed_mac_two,
    input wire logic [31:0] i_access_net_ip,
    input wire logic [31:0] i_access_net_mask,
    input wire logic [7:0] i_ping_timeout_min,
    input wire logic [14:0] i_restart_pulse_width,
    input wire logic i_force_restart_control,
    input wire logic i_mirror_restart_on_relays,
    input wire logic [2:0] i_second_indicator_select,
    input wire logic [2*N-1:0] i_free_port_direction,
    input wire logic [2*N-1:0] i_relay_port_direction,
    input wire logic [N-1:0] i_free_port_pull_select,
    input wire logic [N-1:0] i_relay_port_pull_select,
    input wire logic i_dhcp_offer,
    input wire logic [31:0] i_dhcp_ip,
    input wire logic [31:0] i_dhcp_mask,
    input wire logic [31:0] i_dhcp_gw,
    input wire logic i_frame_valid,
    input wire logic i_frame_tagged,
    input wire logic [11:0] i_frame_vid,
    input wire logic [47:0] i_frame_src_mac,
    input wire logic [31:0] i_frame_src_ip,
    input wire logic i_frame_is_mgmt,
    input wire logic i_echo_req_rx,
    input wire logic i_echo_reply_rx,
    input wire logic i_free_wr,
    input wire logic [N-1:0] i_free_wr_data,
    input wire logic i_relay_wr,
    input wire logic [N-1:0] i_relay_wr_data,
    input wire logic i_saved_valid,
    input wire logic [N-1:0] i_saved_free,
    input wire logic [N-1:0] i_saved_relay,
    input wire logic i_adc_valid,
    input wire logic [2:0] i_adc_chan,
    input wire logic [9:0] i_adc_raw,
    output logic [31:0] o_ip,
    output logic [31:0] o_mask,
    output logic [31:0] o_gw,
    output logic o_dhcp_valid,
    output logic o_net_reconfig,
    output logic o_frame_accept,
    output logic o_echo_req_tx,
    output logic o_target_restart,
    output logic o_ping_led,
    output logic o_second_led,
    output logic [N-1:0] o_free_out,
    output logic [N-1:0] o_free_oe,
    output logic [N-1:0] o_free_pull_en,
    output logic [N-1:0] o_free_pull_down,
    output logic [N-1:0] o_relay_out,
    output logic [N-1:0] o_relay_oe,
    output logic [N-1:0] o_relay_pull_en,
    output logic [N-1:0] o_relay_pull_down,
    output logic o_save_req,
    output logic [N-1:0] o_save_free,
    output logic [N-1:0] o_save_relay,
    output logic o_adc_valid,
    output logic [2:0] o_adc_chan,
    output logic [9:0] o_adc_value
);
    function automatic logic mac_hit(input logic [47:0] cfg, input logic [47:0] src);
        mac_hit = (cfg != 48'h0) && (cfg == src);
    endfunction : mac_hit

    // network settings: dhcp wait then static fallback
    pwio_pkg::pwio_net_t net_state;
    logic [31:0] wait_cnt;
    wire dhcp_on = i_extended_mode_word[`PWIO_BIT_DHCP];
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            net_state <= pwio_pkg::PWIO_NET_WAIT;
            wait_cnt <= 32'h0;
            o_ip <= 32'h0;
            o_mask <= 32'h0;
            o_gw <= 32'h0;
            o_net_reconfig <= 1'b0;
        end else begin
            o_net_reconfig <= 1'b0;
            if (dhcp_on && i_dhcp_offer) begin
                net_state <= pwio_pkg::PWIO_NET_DHCP;
                o_ip <= i_dhcp_ip;
                o_mask <= i_dhcp_mask;
                o_gw <= i_dhcp_gw;
                o_net_reconfig <= 1'b1;
            end else if (!dhcp_on) begin
                net_state <= pwio_pkg::PWIO_NET_STATIC;
                o_ip <= i_device_ip_setting;
                o_mask <= i_subnet_mask_setting;
                o_gw <= i_gateway_setting;
                wait_cnt <= 32'h0;
            end else begin
                unique case (net_state)
                    pwio_pkg::PWIO_NET_WAIT: begin
                        wait_cnt <= wait_cnt + 32'h1;
                        if (wait_cnt >= DHCP_WAIT_CYC - 1) begin
                            net_state <= pwio_pkg::PWIO_NET_STATIC;
                            o_ip <= i_device_ip_setting;
                            o_mask <= i_subnet_mask_setting;
                            o_gw <= i_gateway_setting;
                            o_net_reconfig <= 1'b1;
                        end
                    end
                    pwio_pkg::PWIO_NET_STATIC: wait_cnt <= 32'h0;
                    pwio_pkg::PWIO_NET_DHCP: wait_cnt <= 32'h0;
                endcase
            end
        end
    end
    assign o_dhcp_valid = (net_state == pwio_pkg::PWIO_NET_DHCP);

    // access filter
    wire vlan_mode = i_main_mode_word[`PWIO_BIT_VLAN];
    wire vlan_ok = !vlan_mode || !i_frame_tagged || (i_frame_vid == i_vlan_id_setting);
    wire mac_prot = (i_allowed_mac_one != 48'h0) || (i_allowed_mac_two != 48'h0);
    wire mac_ok = !mac_prot || mac_hit(i_allowed_mac_one, i_frame_src_mac)
        || mac_hit(i_allowed_mac_two, i_frame_src_mac);
    wire net_ok = !i_frame_is_mgmt || (i_access_net_mask == 32'h0)
        || ((i_frame_src_ip & i_access_net_mask) == (i_access_net_ip & i_access_net_mask));
    wire next_accept = i_frame_valid && vlan_ok && mac_ok && net_ok;
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_frame_accept <= 1'b0;
        end else begin
            o_frame_accept <= next_accept;
        end
    end

    // 250 ms tick and minute-based supervision
    logic [31:0] tick_cnt;
    wire tick = (tick_cnt == TICK_CYC - 1);
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || tick) begin
            tick_cnt <= 32'h0;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
        end
    end
    wire [17:0] limit = 18'(i_ping_timeout_min) * 18'(`PWIO_TICKS_PER_MIN);
    wire in_mon = i_extended_mode_word[`PWIO_BIT_IN_MON];
    wire out_mon = i_extended_mode_word[`PWIO_BIT_OUT_MON];
    wire restart_en = i_main_mode_word[`PWIO_BIT_RESTART_EN];
    logic [17:0] in_timer;
    logic [17:0] out_timer;
    logic [5:0] ping_gap;
    logic [14:0] pulse_left;
    logic pulse_on;
    wire in_expire = in_mon && tick && (in_timer >= limit - 18'h1);
    wire out_expire = out_mon && tick && (out_timer >= limit - 18'h1);
    wire start_pulse = restart_en && (in_expire || out_expire);
    wire in_clear = !in_mon || i_echo_req_rx || start_pulse;
    wire out_clear = !out_mon || i_echo_reply_rx || start_pulse;
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            in_timer <= 18'h0;
            out_timer <= 18'h0;
            ping_gap <= 6'h0;
            o_echo_req_tx <= 1'b0;
        end else begin
            if (in_clear) in_timer <= 18'h0;
            else if (tick) in_timer <= in_timer + 18'h1;
            if (out_clear) out_timer <= 18'h0;
            else if (tick) out_timer <= out_timer + 18'h1;
            o_echo_req_tx <= 1'b0;
            if (out_mon && tick) begin
                if (ping_gap == 6'(`PWIO_PING_EVERY_TICKS - 1)) begin
                    ping_gap <= 6'h0;
                    o_echo_req_tx <= 1'b1;
                end else begin
                    ping_gap <= ping_gap + 6'h1;
                end
            end
        end
    end
    // restart pulse; forced control holds it high
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            pulse_left <= 15'h0;
            pulse_on <= 1'b0;
        end else if (start_pulse) begin
            pulse_left <= i_restart_pulse_width;
            pulse_on <= (i_restart_pulse_width != 15'h0);
        end else if (pulse_on && tick) begin
            pulse_left <= pulse_left - 15'h1;
            pulse_on <= (pulse_left != 15'h1);
        end
    end
    wire next_restart = pulse_on || i_force_restart_control;
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) o_target_restart <= 1'b0;
        else o_target_restart <= next_restart;
    end

    // indicators
    logic ping_in_seen;
    logic ping_out_seen;
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_ping_led <= 1'b0;
            ping_in_seen <= 1'b0;
            ping_out_seen <= 1'b0;
        end else begin
            if (i_extended_mode_word[`PWIO_BIT_PING_LED] && i_echo_req_rx) o_ping_led <= !o_ping_led;
            if (i_echo_req_rx) ping_in_seen <= !ping_in_seen;
            if (i_echo_reply_rx) ping_out_seen <= !ping_out_seen;
        end
    end
    logic next_led2;
    always_comb begin
        unique case (i_second_indicator_select)
            3'h0: next_led2 = 1'b1;
            3'h1: next_led2 = ping_in_seen;
            3'h2: next_led2 = ping_out_seen;
            3'h3: next_led2 = ping_in_seen ^ ping_out_seen;
            3'h4: next_led2 = o_dhcp_valid;
            default: next_led2 = 1'b0;
        endcase
    end
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) o_second_led <= 1'b0;
        else o_second_led <= next_led2;
    end

    // digital ports: direction, pulls, output state
    wire no_pull = i_main_mode_word[`PWIO_BIT_NO_PULL];
    logic [N-1:0] free_is_out;
    logic [N-1:0] relay_is_out;
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pin
            assign free_is_out[g] = (i_free_port_direction[2*g+:2] == `PWIO_DIR_OUT);
            assign relay_is_out[g] = (i_relay_port_direction[2*g+:2] == `PWIO_DIR_OUT);
        end
    endgenerate
    wire clr_io = i_extended_mode_word[`PWIO_BIT_CLR_IO] && start_pulse;
    wire retain = i_extended_mode_word[`PWIO_BIT_RETAIN];
    logic booted;
    logic [N-1:0] free_state;
    logic [N-1:0] relay_state;
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            free_state <= '0;
            relay_state <= '0;
            booted <= 1'b0;
            o_save_req <= 1'b0;
        end else begin
            o_save_req <= 1'b0;
            if (clr_io) begin
                free_state <= '0;
                relay_state <= '0;
                o_save_req <= retain;
            end else if (!booted && i_saved_valid) begin
                booted <= 1'b1;
                if (retain) begin
                    free_state <= i_saved_free;
                    relay_state <= i_saved_relay;
                end
            end else begin
                if (i_free_wr) free_state <= i_free_wr_data;
                if (i_relay_wr) relay_state <= i_relay_wr_data;
                o_save_req <= retain && (i_free_wr || i_relay_wr);
            end
        end
    end
    assign o_save_free = free_state;
    assign o_save_relay = relay_state;
    wire [N-1:0] mirror = {N{i_mirror_restart_on_relays && o_target_restart}};
    assign o_free_out = free_state;
    assign o_relay_out = relay_state | mirror;
    assign o_free_oe = free_is_out;
    assign o_relay_oe = relay_is_out;
    assign o_free_pull_en = ~free_is_out & {N{!no_pull}};
    assign o_relay_pull_en = ~relay_is_out & {N{!no_pull}};
    assign o_free_pull_down = i_free_port_pull_select;
    assign o_relay_pull_down = i_relay_port_pull_select;

    pwio_adc_filt #(.CH(8), .W(10)) u_filt (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_filter_on(!i_main_mode_word[`PWIO_BIT_NO_FILTER]),
        .i_valid(i_adc_valid),
        .i_chan(i_adc_chan),
        .i_raw(i_adc_raw),
        .o_valid(o_adc_valid),
        .o_chan(o_adc_chan),
        .o_value(o_adc_value)
    );

    sequence s_expiry;
        start_pulse && i_restart_pulse_width != 15'h0;
    endsequence
    AST_RESTART_FOLLOWS: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        s_expiry |=> ##1 o_target_restart)
        else $error("restart pulse missing after expiry");
    AST_FORCE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_force_restart_control |=> o_target_restart)
        else $error("forced restart not shown");
    AST_CLEAR_IO: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        clr_io |=> free_state == '0 && relay_state == '0)
        else $error("ports not cleared on restart");
    AST_PING_LED: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_extended_mode_word[`PWIO_BIT_PING_LED] && i_echo_req_rx |=> o_ping_led != $past(o_ping_led))
        else $error("ping indicator did not toggle");
    AST_PULL_OFF: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        no_pull |-> o_free_pull_en == '0 && o_relay_pull_en == '0)
        else $error("pull active while disabled");
    AST_OUT_NO_PULL: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (o_free_oe & o_free_pull_en) == '0)
        else $error("pull on output pin");
    AST_DHCP_ADOPT: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        dhcp_on && i_dhcp_offer |=> o_ip == $past(i_dhcp_ip) && o_net_reconfig)
        else $error("dhcp offer not adopted");
    AST_MAC_FIRST: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_frame_valid && !mac_ok |=> !o_frame_accept)
        else $error("frame accepted despite mac mismatch");
    AST_IN_RESTART: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        in_mon && i_echo_req_rx |=> in_timer == 18'h0)
        else $error("incoming timer not restarted");
endmodule : pwio_top

// File: verif/pwio_host_model.sv
/*
 * network host model: frames, echo requests, echo replies and dhcp offers.
 * assumes the block's clock; drives by non-blocking assignment at rising edges.
 */
`timescale 1ns/10ps
module pwio_host_model (
    input wire logic i_clock,
    input wire logic i_echo_req_tx,
    input wire logic i_reply_on,
    input wire logic [7:0] i_reply_dly,
    output logic o_frame_valid,
    output logic o_frame_tagged,
    output logic [11:0] o_frame_vid,
    output logic [47:0] o_frame_src_mac,
    output logic [31:0] o_frame_src_ip,
    output logic o_frame_is_mgmt,
    output logic o_echo_req_rx,
    output logic o_echo_reply_rx,
    output logic o_dhcp_offer,
    output logic [31:0] o_dhcp_ip
);
    initial begin
        {o_frame_valid, o_frame_tagged, o_frame_vid, o_frame_src_mac, o_frame_src_ip, o_frame_is_mgmt} = '0;
        {o_echo_req_rx, o_echo_reply_rx, o_dhcp_offer, o_dhcp_ip} = '0;
    end
    // answer each echo request after a chosen delay while replies are switched on
    always @(posedge i_clock) begin
        if (i_echo_req_tx === 1'b1 && i_reply_on) begin
            repeat (i_reply_dly) @(posedge i_clock);
            o_echo_reply_rx <= 1'b1;
            @(posedge i_clock);
            o_echo_reply_rx <= 1'b0;
        end
    end
    task automatic frame(input logic t, input logic [11:0] v, input logic [47:0] m, input logic [31:0] a,
                         input logic g);
        @(posedge i_clock);
        o_frame_valid <= 1'b1;
        {o_frame_tagged, o_frame_vid, o_frame_src_mac, o_frame_src_ip, o_frame_is_mgmt} <= {t, v, m, a, g};
        @(posedge i_clock);
        o_frame_valid <= 1'b0;
        // unqualified fields show the inverse
        {o_frame_tagged, o_frame_vid, o_frame_src_mac, o_frame_src_ip, o_frame_is_mgmt} <= ~{t, v, m, a, g};
    endtask : frame
    task automatic ping();
        @(posedge i_clock);
        o_echo_req_rx <= 1'b1;
        @(posedge i_clock);
        o_echo_req_rx <= 1'b0;
    endtask : ping
    task automatic offer(input logic [31:0] a);
        @(posedge i_clock);
        o_dhcp_offer <= 1'b1;
        o_dhcp_ip <= a;
        @(posedge i_clock);
        o_dhcp_offer <= 1'b0;
        o_dhcp_ip <= ~a;
    endtask : offer
endmodule : pwio_host_model

// File: verif/testbench.sv
/*
 * testbench of the echo supervision and i/o setup block.
 * assumes short counts: dhcp wait 100 cycles, 250 ms tick of 4 cycles.
 */
`timescale 1ns/10ps
module testbench;
    localparam logic [47:0] GM = 48'h0A0B_0C0D_0E0F;
    logic i_clock, i_rst_n, i_force_restart_control, i_mirror_restart_on_relays, i_dhcp_offer, i_frame_valid;
    logic i_frame_tagged, i_frame_is_mgmt, i_echo_req_rx, i_echo_reply_rx, i_free_wr, i_relay_wr, i_saved_valid;
    logic i_adc_valid, reply_on, o_dhcp_valid, o_net_reconfig, o_frame_accept, o_echo_req_tx, o_target_restart;
    logic o_ping_led, o_second_led, o_save_req, o_adc_valid;
    logic [7:0] i_main_mode_word, i_extended_mode_word, i_ping_timeout_min, i_free_wr_data, i_relay_wr_data;
    logic [7:0] i_saved_free, i_saved_relay, i_free_port_pull_select, i_relay_port_pull_select, reply_dly;
    logic [7:0] o_free_out, o_free_oe, o_free_pull_en, o_free_pull_down, o_relay_out, o_relay_oe;
    logic [7:0] o_relay_pull_en, o_relay_pull_down, o_save_free, o_save_relay;
    logic [31:0] i_device_ip_setting, i_subnet_mask_setting, i_gateway_setting, i_access_net_ip, i_access_net_mask;
    logic [31:0] i_dhcp_ip, i_dhcp_mask, i_dhcp_gw, i_frame_src_ip, o_ip, o_mask, o_gw;
    logic [47:0] i_allowed_mac_one, i_allowed_mac_two, i_frame_src_mac;
    logic [15:0] i_free_port_direction, i_relay_port_direction;
    logic [11:0] i_vlan_id_setting, i_frame_vid;
    logic [14:0] i_restart_pulse_width;
    logic [9:0] i_adc_raw, o_adc_value;
    logic [2:0] i_second_indicator_select, i_adc_chan, o_adc_chan;
    int fails, total_checks, hi, tx, h0, t0, w;
    assign i_dhcp_mask = ~i_dhcp_ip;
    assign i_dhcp_gw = i_dhcp_ip + 32'h0000_0001;
    pwio_top #(.N(8), .DHCP_WAIT_CYC(100), .TICK_CYC(4)) uut (.*);
    pwio_host_model host (.i_clock(i_clock), .i_echo_req_tx(o_echo_req_tx), .i_reply_on(reply_on),
        .i_reply_dly(reply_dly), .o_frame_valid(i_frame_valid), .o_frame_tagged(i_frame_tagged),
        .o_frame_vid(i_frame_vid), .o_frame_src_mac(i_frame_src_mac), .o_frame_src_ip(i_frame_src_ip),
        .o_frame_is_mgmt(i_frame_is_mgmt), .o_echo_req_rx(i_echo_req_rx), .o_echo_reply_rx(i_echo_reply_rx),
        .o_dhcp_offer(i_dhcp_offer), .o_dhcp_ip(i_dhcp_ip));
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        if (o_target_restart === 1'b1) hi <= hi + 1;
        if (o_echo_req_tx === 1'b1) tx <= tx + 1;
    end
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge i_clock);
        #1;
    endtask : cyc
    task automatic wr(input logic rel, input logic [7:0] d);
        @(posedge i_clock);
        {i_relay_wr, i_free_wr} <= {rel, ~rel};
        {i_relay_wr_data, i_free_wr_data} <= {d, d};
        cyc(1);
        {i_relay_wr, i_free_wr} <= 2'b00;
    endtask : wr
    task automatic adc(input logic [9:0] r);
        @(posedge i_clock);
        i_adc_valid <= 1'b1;
        i_adc_raw <= r;
        cyc(1);
        i_adc_valid <= 1'b0;
        chk(o_adc_valid, 1);
    endtask : adc
    task automatic frm(input logic t, input logic [11:0] v, input logic [47:0] m, input logic [31:0] a,
                       input logic g, input logic e);
        host.frame(t, v, m, a, g);
        #1;
        chk(o_frame_accept, e);
    endtask : frm
    task automatic wait_hi();
        w = 0;
        while (o_target_restart !== 1'b1 && w < 1100) begin
            cyc(1);
            w++;
        end
    endtask : wait_hi
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test
    initial begin
        #1000000;
        fails++;
        finish_test();
    end
    initial begin
        {i_rst_n, i_force_restart_control, i_mirror_restart_on_relays, i_free_wr, i_relay_wr} = '0;
        {i_saved_valid, i_adc_valid, i_adc_raw, i_free_wr_data, i_relay_wr_data, i_saved_free, i_saved_relay} = '0;
        {fails, total_checks, hi, tx, reply_on, i_allowed_mac_two, i_relay_port_pull_select, i_adc_chan} = '0;
        {i_main_mode_word, i_extended_mode_word, reply_dly} = {8'h00, 8'h21, 8'h14};
        {i_device_ip_setting, i_subnet_mask_setting, i_gateway_setting} = {32'hC0A8_0102, ~32'hFF, 32'hC0A8_0101};
        {i_access_net_ip, i_access_net_mask, i_vlan_id_setting} = {32'hC0A8_0100, ~32'hFF, 12'hFFF};
        {i_allowed_mac_one, i_ping_timeout_min, i_restart_pulse_width} = {GM, 8'h01, 15'h0002};
        {i_second_indicator_select, i_free_port_direction, i_relay_port_direction} = {3'h0, 16'hFA55, 16'h5555};
        i_free_port_pull_select = 8'hC6;
        repeat (16) @(posedge i_clock);
        i_rst_n <= 1'b1;
        cyc(60);
        chk(o_dhcp_valid, 0);
        cyc(60);
        chk(o_ip, 32'hC0A8_0102);
        host.offer(32'h0A00_0007);
        #1;
        chk(o_net_reconfig, 1);
        cyc(1);
        chk({o_ip, o_mask}, {32'h0A00_0007, ~32'h0A00_0007});
        chk(o_gw, 32'h0A00_0008);
        chk(o_dhcp_valid, 1);
        i_second_indicator_select <= 3'h4;
        cyc(3);
        chk(o_second_led, 1);
        $display("test network finished");
        chk({o_free_oe, o_relay_oe, o_free_pull_en, o_relay_pull_en}, 32'h0FFF_F000);
        chk(o_free_pull_down & 8'hF0, 8'hC0);
        i_main_mode_word <= 8'h0B;
        cyc(2);
        chk(o_free_pull_en, 0);
        wr(0, 8'hA5);
        chk({o_free_out, o_save_req, o_save_free}, {8'hA5, 1'b1, 8'hA5});
        $display("test ports finished");
        frm(1, 12'hFFF, GM, 32'hC0A8_0109, 1, 1);
        frm(1, 12'h0FE, GM, 32'hC0A8_0109, 1, 0);
        frm(0, 12'h0FE, GM, 32'hC0A8_0109, 1, 1);
        frm(0, 12'hFFF, ~GM, 32'hC0A8_0109, 1, 0);
        frm(0, 12'hFFF, GM, 32'hC0A8_0209, 1, 0);
        frm(0, 12'hFFF, GM, 32'hC0A8_0209, 0, 1);
        frm(0, 12'hFFF, ~GM, 32'hC0A8_0209, 0, 0);
        i_allowed_mac_one <= '0;
        frm(0, 12'hFFF, ~GM, 32'hC0A8_0109, 1, 1);
        $display("test frames finished");
        i_extended_mode_word <= 8'h31;
        repeat (3) host.ping();
        cyc(2);
        chk(o_ping_led, 1);
        i_second_indicator_select <= 3'h2;
        cyc(2);
        chk(o_second_led, 0);
        adc(10'h2AB);
        chk(o_adc_value, 10'h055);
        i_main_mode_word <= 8'h1B;
        adc(10'h2AB);
        chk(o_adc_value, 10'h2AB);
        i_main_mode_word <= 8'h0E;
        i_extended_mode_word <= 8'h2B;
        wr(1, 8'h81);
        h0 = hi;
        wait_hi();
        chk(w < 1100, 1);
        cyc(12);
        chk(hi - h0, 8);
        chk({o_free_out, o_relay_out}, 0);
        host.ping();
        h0 = hi;
        wait_hi();
        chk(w > 930 && w < 985, 1);
        cyc(12);
        $display("test incoming finished");
        i_extended_mode_word <= 8'h2D;
        reply_on <= 1'b1;
        {h0, t0} = {hi, tx};
        cyc(1600);
        chk(tx - t0 >= 9 && tx - t0 <= 11, 1);
        chk(hi, h0);
        reply_on <= 1'b0;
        wait_hi();
        chk(w < 1100, 1);
        cyc(12);
        i_extended_mode_word <= 8'h20;
        {i_force_restart_control, i_mirror_restart_on_relays} <= 2'b11;
        cyc(3);
        chk({o_target_restart, o_relay_out}, {1'b1, 8'hFF});
        i_force_restart_control <= 1'b0;
        cyc(3);
        chk(o_target_restart, 0);
        $display("test restart finished");
        wr(0, 8'h3C);
        i_mirror_restart_on_relays <= 1'b0;
        i_rst_n <= 1'b0;
        cyc(16);
        chk(o_free_out, 0);
        i_rst_n <= 1'b1;
        {i_saved_valid, i_saved_free, i_saved_relay} <= {1'b1, 8'h5A, 8'hC3};
        cyc(1);
        i_saved_valid <= 1'b0;
        cyc(1);
        chk({o_free_out, o_relay_out}, 16'h5AC3);
        $display("test boot finished");
        finish_test();
    end
endmodule : testbench
